// *** src/ppst_consts.svh ***
// Constants for the parallel pixel serializer transmitter.
// Assumes it is included by bare name wherever the figures are needed.
`ifndef PPST_CONSTS_SVH
`define PPST_CONSTS_SVH

// Word layout: three lanes of seven slots carry the 21 captured bits.
`define PPST_WORD_W       21
`define PPST_LANES        3
`define PPST_SLOTS        7
`define PPST_SLOT_W       3
`define PPST_SLOT_LAST    3'h6
`define PPST_SLOT_FIRST   3'h0

// Forwarded clock: high for the first four slots, low for the last three.
`define PPST_FWD_HIGH     3'h4

// Timing figures in their own units and the derived cycle counts.
`define PPST_CLK_NS       50
`define PPST_LOCK_MS      10
`define PPST_LOCK_CYCLES  ((`PPST_LOCK_MS * 1000000) / `PPST_CLK_NS)
`define PPST_PD_DELAY_NS  100
`define PPST_PD_CYCLES    ((`PPST_PD_DELAY_NS / `PPST_CLK_NS) < 1 ? 1 : \
                           (`PPST_PD_DELAY_NS / `PPST_CLK_NS))
`define PPST_FWD_DELAY_PS 5500
`define PPST_MAX_PIX_NS   50

`endif

// *** src/ppst_pkg.sv ***
// Types shared by the parallel pixel serializer transmitter.
// Assumes nothing of its surroundings.
package ppst_pkg;

  typedef enum logic [2:0]
  {
    PPST_OFF  = 3'b001,
    PPST_LOCK = 3'b010,
    PPST_RUN  = 3'b100
  } ppst_state_e;

endpackage

// *** src/ppst_tx.sv ***
// Parallel pixel serializer transmitter: captures 21 bits per pixel clock
// and sends them as seven slots on each of three lanes plus a forwarded clock.
// Assumes clk is the slot clock of the locked loop (one slot per clk cycle)
// and that pixel_clock_in comes from the display controller, unrelated in phase.
//
// What this block does
// - Capture all 21 inputs together on each falling pixel clock edge.
// - The word pending at each frame boundary goes out on three lanes, seven slots each.
// - Slots are evenly spaced, slot 0 at the reference edge.
// - A forwarded clock at the frame rate runs on a fourth output.
// - Power-down low tri-states the lanes and forwarded clock and halts the slot counter and lock timer; pixel capture keeps running.
// - Outputs are disabled at most 100 ns after power-down goes low.
// - Serial output is invalid until the loop has locked, up to 10 ms.
`include "ppst_consts.svh"

module ppst_tx
#(
  parameter int LOCK_CYCLES = `PPST_LOCK_CYCLES
)
(
  // Slot clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Pixel side
  input  wire logic                    pixel_clock_in,
  input  wire logic [`PPST_WORD_W-1:0] parallel_pixel_in,
  input  wire logic                    power_down_n,
  // Serial side
  output logic [`PPST_LANES-1:0]       serial_lane_out,
  output logic                         serial_lane_oe,
  output logic                         forwarded_clock_out,
  output logic                         forwarded_clock_oe,
  output logic                         pll_locked
);

  // A lock time of zero cycles would wrap the compare to all ones, so run would come only after 2^32 cycles of lock.
  if (LOCK_CYCLES < 1)
  begin : g_bad_lock
    $error("LOCK_CYCLES must be at least one");
  end

  // ---------------- Pixel clock domain ----------------

  logic                    px_rst_s1_reg;
  logic                    px_rst_s2_reg;
  logic                    wr_bank_reg;
  logic [`PPST_WORD_W-1:0] bank0_reg;
  logic [`PPST_WORD_W-1:0] bank1_reg;

  // The reset is brought into the pixel domain so the bank pointer starts known.
  always_ff @(negedge pixel_clock_in)
  begin
    px_rst_s1_reg <= reset;
    px_rst_s2_reg <= px_rst_s1_reg;
  end

  // Ping-pong banks: a word is never overwritten while the slot side reads it.
  always_ff @(negedge pixel_clock_in)
  begin
    if (px_rst_s2_reg)
      wr_bank_reg <= 1'b0;
    else
      wr_bank_reg <= ~wr_bank_reg;
  end

  always_ff @(negedge pixel_clock_in)
  begin
    if (!px_rst_s2_reg && !wr_bank_reg)
      bank0_reg <= parallel_pixel_in;
    if (!px_rst_s2_reg && wr_bank_reg)
      bank1_reg <= parallel_pixel_in;
  end

  a_capture_toggles: assert property (@(negedge pixel_clock_in)
    !px_rst_s2_reg |=> wr_bank_reg != $past(wr_bank_reg))
    else $error("Pixel capture did not advance on a falling edge.");

  // ---------------- Slot clock domain ----------------

  logic                    wr_s1_reg;
  logic                    wr_s2_reg;
  logic                    wr_s3_reg;
  logic                    pd_s1_reg;
  logic                    pd_s2_reg;
  logic                    new_word;
  logic [`PPST_WORD_W-1:0] pending_reg;
  logic [`PPST_WORD_W-1:0] cur_word_reg;
  logic [`PPST_SLOT_W-1:0] slot_reg;
  logic [31:0]             lock_cnt_reg;
  ppst_pkg::ppst_state_e   state_reg;
  ppst_pkg::ppst_state_e   state_next;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_s1_reg <= 1'b0;
      wr_s2_reg <= 1'b0;
      wr_s3_reg <= 1'b0;
    end
    else
    begin
      wr_s1_reg <= wr_bank_reg;
      wr_s2_reg <= wr_s1_reg;
      wr_s3_reg <= wr_s2_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pd_s1_reg <= 1'b0;
      pd_s2_reg <= 1'b0;
    end
    else
    begin
      pd_s1_reg <= power_down_n;
      pd_s2_reg <= pd_s1_reg;
    end
  end

  assign new_word = wr_s2_reg ^ wr_s3_reg;

  // The bank just finished is the one the pointer has left.
  always_ff @(posedge clk)
  begin
    if (reset)
      pending_reg <= '0;
    else if (new_word)
      pending_reg <= wr_s2_reg ? bank0_reg : bank1_reg;
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ppst_pkg::PPST_OFF:
        if (pd_s2_reg)
          state_next = ppst_pkg::PPST_LOCK;
      ppst_pkg::PPST_LOCK:
        if (!pd_s2_reg)
          state_next = ppst_pkg::PPST_OFF;
        else if (lock_cnt_reg == 32'(LOCK_CYCLES - 1))
          state_next = ppst_pkg::PPST_RUN;
      ppst_pkg::PPST_RUN:
        if (!pd_s2_reg)
          state_next = ppst_pkg::PPST_OFF;
      default:
        state_next = ppst_pkg::PPST_OFF;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_reg <= ppst_pkg::PPST_OFF;
    else
      state_reg <= state_next;
  end

  // Lock time restarts on every exit from power-down.
  always_ff @(posedge clk)
  begin
    if (reset || state_reg != ppst_pkg::PPST_LOCK)
      lock_cnt_reg <= 32'h0000_0000;
    else
      lock_cnt_reg <= lock_cnt_reg + 32'h0000_0001;
  end

  // The slot counter stands still in power-down to keep activity down.
  always_ff @(posedge clk)
  begin
    if (reset || state_reg == ppst_pkg::PPST_OFF)
      slot_reg <= `PPST_SLOT_FIRST;
    else if (slot_reg == `PPST_SLOT_LAST)
      slot_reg <= `PPST_SLOT_FIRST;
    else
      slot_reg <= slot_reg + 3'h1;
  end

  // A word is taken only at a frame boundary; if none arrived, the last repeats.
  always_ff @(posedge clk)
  begin
    if (reset)
      cur_word_reg <= '0;
    else if (slot_reg == `PPST_SLOT_LAST)
      cur_word_reg <= pending_reg;
  end

  generate
    for (genvar i = 0; i < `PPST_LANES; i++)
    begin : g_lane
      always_ff @(posedge clk)
      begin
        if (reset || state_reg != ppst_pkg::PPST_RUN)
          serial_lane_out[i] <= 1'b0;
        else
          serial_lane_out[i] <= cur_word_reg[`PPST_SLOTS * i + int'(slot_reg)];
      end

      a_lane_mapping: assert property (@(posedge clk) disable iff (reset)
        $past(state_reg) == ppst_pkg::PPST_RUN && $past(state_reg, 2) == ppst_pkg::PPST_RUN
        |-> serial_lane_out[i] == $past(cur_word_reg[`PPST_SLOTS * i + int'(slot_reg)]))
        else $error("Lane bit does not match its mapped input.");
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (reset || state_reg != ppst_pkg::PPST_RUN)
      forwarded_clock_out <= 1'b0;
    else
      forwarded_clock_out <= (slot_reg < `PPST_FWD_HIGH);
  end

  // Enables follow the second synchroniser stage, two edges after the pin falls.
  assign serial_lane_oe     = pd_s2_reg;
  assign forwarded_clock_oe = pd_s2_reg;
  assign pll_locked         = (state_reg == ppst_pkg::PPST_RUN);

  // ---------------- Checks ----------------

  logic [3:0] pd_low_cnt_reg;

  // This counter watches the raw pin on purpose: the delay bound is measured from the pin.
  always_ff @(posedge clk)
  begin
    if (reset || power_down_n)
      pd_low_cnt_reg <= 4'h0;
    else if (pd_low_cnt_reg != 4'hf)
      pd_low_cnt_reg <= pd_low_cnt_reg + 4'h1;
  end

  a_pd_delay_bound: assert property (@(posedge clk) disable iff (reset)
    pd_low_cnt_reg >= 4'(`PPST_PD_CYCLES) |-> !serial_lane_oe && !forwarded_clock_oe)
    else $error("Outputs still enabled after the power-down delay.");

  // The state leaves first; the slot counter only clears once the state reads off.
  a_pd_quiet: assert property (@(posedge clk) disable iff (reset)
    !pd_s2_reg |=> !pll_locked ##1 slot_reg == `PPST_SLOT_FIRST)
    else $error("Activity continued during power-down.");

  a_pd_lanes_off: assert property (@(posedge clk) disable iff (reset)
    !pd_s2_reg |-> ##2 serial_lane_out == '0 && !forwarded_clock_out)
    else $error("Outputs still toggling during power-down.");

  a_oe_prompt: assert property (@(posedge clk) disable iff (reset)
    !pd_s1_reg |=> !serial_lane_oe)
    else $error("Output enable lagged the power-down synchroniser.");

  a_slot_wrap: assert property (@(posedge clk) disable iff (reset)
    slot_reg == `PPST_SLOT_LAST && pd_s2_reg |=> slot_reg == `PPST_SLOT_FIRST)
    else $error("Slot counter did not wrap after seven slots.");

  a_slot_step: assert property (@(posedge clk) disable iff (reset)
    state_reg != ppst_pkg::PPST_OFF && slot_reg != `PPST_SLOT_LAST
    |=> slot_reg == $past(slot_reg) + 3'h1)
    else $error("Slots are not evenly spaced.");

  // A power-down in mid-frame cuts the pattern short, which is legal.
  a_fwd_pattern: assert property (@(posedge clk) disable iff (reset || !pd_s2_reg)
    pll_locked && slot_reg == `PPST_SLOT_FIRST
    |=> forwarded_clock_out [*4] ##1 (!forwarded_clock_out || !pll_locked))
    else $error("Forwarded clock pattern is not four high, three low.");

  a_no_data_unlocked: assert property (@(posedge clk) disable iff (reset)
    !pll_locked |=> serial_lane_out == '0 && !forwarded_clock_out)
    else $error("Serial output driven before lock.");

  a_lock_time: assert property (@(posedge clk) disable iff (reset)
    $rose(pll_locked) |-> $past(lock_cnt_reg) == 32'(LOCK_CYCLES - 1))
    else $error("Lock declared after the wrong number of cycles.");

  a_frame_load: assert property (@(posedge clk) disable iff (reset)
    slot_reg == `PPST_SLOT_LAST |=> cur_word_reg == $past(pending_reg))
    else $error("Word not loaded at the frame boundary.");

  // A word that changed in mid-frame would tear across the lanes.
  a_word_hold: assert property (@(posedge clk) disable iff (reset)
    slot_reg != `PPST_SLOT_LAST |=> $stable(cur_word_reg))
    else $error("Transmitted word changed inside a frame.");

  a_slot_range: assert property (@(posedge clk) disable iff (reset)
    slot_reg <= `PPST_SLOT_LAST)
    else $error("Slot counter left the seven-slot range.");

  a_fwd_tail: assert property (@(posedge clk) disable iff (reset)
    pll_locked && slot_reg == `PPST_FWD_HIGH |=> !forwarded_clock_out [*3])
    else $error("Forwarded clock not low for the last three slots.");

  // Each exit from power-down must wait the full lock time again.
  a_lock_restart: assert property (@(posedge clk) disable iff (reset)
    state_reg != ppst_pkg::PPST_LOCK |=> lock_cnt_reg == 32'h0000_0000)
    else $error("Lock timer kept a count outside the lock state.");

  a_state_onehot: assert property (@(posedge clk) disable iff (reset)
    $onehot(state_reg))
    else $error("Power state register is not one-hot.");

endmodule

// *** test/ppst_rx_model.sv ***
// Behavioural receiver that sits on the far side of the serial link.
// Assumes it shares the slot clock with the transmitter and sees one slot per rising edge.
`include "ppst_consts.svh"

module ppst_rx_model
(
  // Slot clock
  input  wire logic                    clk,
  // Link
  input  wire logic [`PPST_LANES-1:0]  serial_lane_out,
  input  wire logic                    serial_lane_oe,
  input  wire logic                    forwarded_clock_out,
  // Recovered word and slots between the last two frames
  output logic      [`PPST_WORD_W-1:0] rx_word,
  output logic      [3:0]              rx_gap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] sh [`PPST_LANES];
  logic [6:0] fh  = 7'h00;
  logic [3:0] cnt = 4'h0;

  initial rx_word = 21'h000000;
  initial rx_gap = 4'h0;

  // Alignment comes only from the forwarded clock, so a wrong pattern stalls every word.
  always @(posedge clk)
  begin
    for (int i = 0; i < `PPST_LANES; i++)
      sh[i] = {serial_lane_out[i], sh[i][6:1]};
    fh = serial_lane_oe ? {forwarded_clock_out, fh[6:1]} : 7'h00;
    cnt = (cnt == 4'hf) ? cnt : cnt + 4'h1;
    if (fh == 7'h0f)
    begin
      for (int i = 0; i < `PPST_WORD_W; i++)
        rx_word[i] = sh[i / `PPST_SLOTS][i % `PPST_SLOTS];
      rx_gap = cnt;
      cnt = 4'h0;
    end
  end
endmodule

// *** test/testbench.sv ***
// Self-checking bench: the transmitter facing the receiver model.
// Assumes the pixel clock runs free from the controller, unrelated to clk.
`include "ppst_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOCK = 20;
  logic                    clk = 1'b0;
  logic                    reset = 1'b1;
  logic                    pixel_clock_in = 1'b1;
  logic [`PPST_WORD_W-1:0] parallel_pixel_in = 21'h000000;
  logic                    power_down_n = 1'b1;
  logic [`PPST_LANES-1:0]  serial_lane_out;
  logic                    serial_lane_oe;
  logic                    forwarded_clock_out;
  logic                    forwarded_clock_oe;
  logic                    pll_locked;
  logic [`PPST_WORD_W-1:0] rx_word;
  logic [3:0]              rx_gap;
  logic [20:0]             words [4] = '{21'h000001, 21'h100000, 21'h0aaaaa, 21'h1f80fe};
  int                      fails = 0;
  int                      checked = 0;
  int                      cycles = 0;

  always #25 clk = ~clk;

  // The controller keeps its clock running without pause for the whole run.
  initial
  begin
    #17;
    forever #62.5 pixel_clock_in = ~pixel_clock_in;
  end

  ppst_tx #(.LOCK_CYCLES(LOCK)) u_ppst_tx (.clk(clk), .reset(reset),
    .pixel_clock_in(pixel_clock_in), .parallel_pixel_in(parallel_pixel_in),
    .power_down_n(power_down_n), .serial_lane_out(serial_lane_out),
    .serial_lane_oe(serial_lane_oe), .forwarded_clock_out(forwarded_clock_out),
    .forwarded_clock_oe(forwarded_clock_oe), .pll_locked(pll_locked));

  ppst_rx_model u_ppst_rx_model (.clk(clk), .serial_lane_out(serial_lane_out),
    .serial_lane_oe(serial_lane_oe), .forwarded_clock_out(forwarded_clock_out),
    .rx_word(rx_word), .rx_gap(rx_gap));

  task check(string name, logic [20:0] seen, logic [20:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      wrap_up();
    end
  end

  task wait_lock;
    int n;
    n = 0;
    while (pll_locked !== 1'b1 && n < LOCK + 40)
    begin
      check("lanes_before_lock", {18'h0, serial_lane_out}, 21'h0);
      @(negedge clk);
      n++;
    end
    check("lock_window", 21'(n >= LOCK && n <= LOCK + 6), 21'h1);
  endtask

  task send_word(logic [20:0] w);
    parallel_pixel_in = w;
    repeat (40) @(negedge clk);
    check("rx_word", rx_word, w);
    check("frame_gap", {17'h0, rx_gap}, 21'h7);
  endtask

  task power_cycle;
    power_down_n = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("oe_off", {19'h0, serial_lane_oe, forwarded_clock_oe}, 21'h0);
    // Lanes are registered from the state, which leaves one edge after the enables drop.
    repeat (2) @(negedge clk);
    check("lanes_off", {16'h0, serial_lane_out, forwarded_clock_out, pll_locked}, 21'h0);
    power_down_n = 1'b1;
    wait_lock();
    check("oe_on", {19'h0, serial_lane_oe, forwarded_clock_oe}, 21'h3);
  endtask

  initial
  begin
    repeat (10) @(negedge clk);
    check("reset_out", {15'h0, serial_lane_out, serial_lane_oe, forwarded_clock_out, pll_locked},
          21'h0);
    reset = 1'b0;
    wait_lock();
    foreach (words[i])
      send_word(words[i]);
    power_cycle();
    send_word(21'h15a5a5);
    wrap_up();
  end
endmodule
